// >>> shared/pci_target_pkg.sv
package pci_target_pkg;

  // ----------------------------------------
  // bus commands
  // ----------------------------------------
  localparam logic [3:0] CMD_IO_RD   = 4'h2;
  localparam logic [3:0] CMD_IO_WR   = 4'h3;
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_CFG_RD  = 4'ha;
  localparam logic [3:0] CMD_CFG_WR  = 4'hb;
  localparam logic [3:0] CMD_MEM_RDM = 4'hc;
  localparam logic [3:0] CMD_MEM_RDL = 4'he;
  localparam logic [3:0] CMD_MEM_WRI = 4'hf;

  // ----------------------------------------
  // decode constants
  // ----------------------------------------
  localparam logic [1:0] CFG_TYPE0_CODE     = 2'h0;
  localparam logic [1:0] DEVSEL_TIMING_MED  = 2'h1;
  localparam int         CSR_IO_SPAN_BITS   = 5;
  localparam int         CSR_MEM_SPAN_BITS  = 12;
  localparam int         FLASH_SPAN_BITS    = 20;
  localparam int         FLASH_RD_MAX_BYTES = 2;
  localparam int         FLASH_WR_MAX_BYTES = 1;
  localparam int         FLASH_WAIT_DEFAULT = 4;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic        frame_n;
    logic        irdy_n;
    logic        idsel;
    logic [3:0]  cbe_n;
    logic [31:0] ad;
  } pci_in_t;

  typedef struct packed {
    logic [31:0] ad;
    logic        ad_oe;
    logic        devsel_n;
    logic        trdy_n;
    logic        stop_n;
    logic        ctl_oe;
  } pci_out_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [5:0]  idx;
    logic [3:0]  be;
    logic [31:0] wdata;
  } acc_req_t;

  typedef struct packed {
    logic [31:0] csr_mem_base;
    logic [31:0] csr_io_base;
    logic [31:0] flash_base;
    logic [31:0] rom_base;
    logic        mem_space_en;
    logic        io_space_en;
    logic        rom_en;
  } bar_cfg_t;

  typedef struct packed {
    logic [19:0] addr;
    logic        rd_en;
    logic        wr_en;
    logic [7:0]  wdata;
  } flash_pins_t;

  localparam pci_out_t PCI_OUT_IDLE = '{ad: 32'h0, ad_oe: 1'b0, devsel_n: 1'b1,
                                        trdy_n: 1'b1, stop_n: 1'b1, ctl_oe: 1'b0};
  localparam acc_req_t ACC_REQ_IDLE = '{rd: 1'b0, wr: 1'b0, idx: 6'h0, be: 4'h0,
                                        wdata: 32'h0};
  localparam flash_pins_t FLASH_PINS_IDLE = '{addr: 20'h0, rd_en: 1'b0, wr_en: 1'b0,
                                              wdata: 8'h0};

endpackage

// >>> rtl/flash_byte_engine.sv
`timescale 1ns/100ps
module flash_byte_engine #(
  parameter int WAIT_CYCLES = pci_target_pkg::FLASH_WAIT_DEFAULT
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        start,
  input  wire logic                        write,
  input  wire logic [19:0]                 addr,
  input  wire logic [3:0]                  be,
  input  wire logic [31:0]                 wdata,
  output logic                             done,
  output logic [31:0]                      rdata,
  output pci_target_pkg::flash_pins_t      fl_pins,
  input  wire logic [7:0]                  fl_rdata
);

  initial begin
    if (WAIT_CYCLES < 2 || WAIT_CYCLES > 255) begin
      $error("flash wait count out of range");
    end
  end

  // keep the lowest n enabled lanes only
  function automatic logic [3:0] limit_lanes(input logic [3:0] m, input int n);
    logic [3:0] r;
    int         c;
    r = 4'h0;
    c = 0;
    for (int i = 0; i < 4; i++) begin
      if (m[i] && c < n) begin
        r[i] = 1'b1;
        c++;
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] low_lane(input logic [3:0] m);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (m[i]) r = 2'(i);
    end
    return r;
  endfunction

  logic [3:0]  mask_reg;
  logic [7:0]  cnt_reg;
  logic        busy_reg;
  logic        write_reg;
  logic [17:0] base_reg;
  logic [31:0] wdata_reg;
  logic [1:0]  lane;
  logic        step_end;

  assign lane     = low_lane(mask_reg);
  assign step_end = busy_reg && (mask_reg != 4'h0) && (cnt_reg == 8'(WAIT_CYCLES - 1));

  // ----------------------------------------
  // byte sequencing
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg  <= 1'b0;
      mask_reg  <= 4'h0;
      cnt_reg   <= 8'h0;
      write_reg <= 1'b0;
      base_reg  <= 18'h0;
      wdata_reg <= 32'h0;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy_reg) begin
        busy_reg  <= 1'b1;
        write_reg <= write;
        base_reg  <= addr[19:2];
        wdata_reg <= wdata;
        cnt_reg   <= 8'h0;
        mask_reg  <= write ? limit_lanes(be, pci_target_pkg::FLASH_WR_MAX_BYTES)
                           : limit_lanes(be, pci_target_pkg::FLASH_RD_MAX_BYTES);
      end else if (busy_reg) begin
        if (mask_reg == 4'h0) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end else if (step_end) begin
          mask_reg[lane] <= 1'b0;
          cnt_reg        <= 8'h0;
        end else begin
          cnt_reg <= cnt_reg + 8'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // flash pins, held steady for the whole byte access
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fl_pins <= pci_target_pkg::FLASH_PINS_IDLE;
    end else if (busy_reg && mask_reg != 4'h0 && !step_end) begin
      fl_pins.addr  <= {base_reg, lane};
      fl_pins.rd_en <= !write_reg;
      fl_pins.wr_en <= write_reg;
      fl_pins.wdata <= wdata_reg[8*lane +: 8];
    end else begin
      fl_pins.rd_en <= 1'b0;
      fl_pins.wr_en <= 1'b0;
    end
  end

  // ----------------------------------------
  // read assembly, one lane per byte
  // ----------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_lane
    always_ff @(posedge clk) begin
      if (rst || (start && !busy_reg)) begin
        rdata[8*g +: 8] <= 8'h0;
      end else if (step_end && !write_reg && lane == 2'(g)) begin
        rdata[8*g +: 8] <= fl_rdata;
      end
    end
  end

endmodule

// >>> rtl/pci_target_cfg_csr_flash.sv
`timescale 1ns/100ps
module pci_target_cfg_csr_flash #(
  parameter int FLASH_WAIT = pci_target_pkg::FLASH_WAIT_DEFAULT
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire pci_target_pkg::pci_in_t     pci_i,
  output pci_target_pkg::pci_out_t         pci_o,
  input  wire pci_target_pkg::bar_cfg_t    bars,
  output pci_target_pkg::acc_req_t         cfg_req,
  input  wire logic [31:0]                 cfg_rdata,
  output pci_target_pkg::acc_req_t         csr_req,
  input  wire logic [31:0]                 csr_rdata,
  output pci_target_pkg::flash_pins_t      fl_pins,
  input  wire logic [7:0]                  fl_rdata,
  output logic [1:0]                       devsel_timing
);

  initial begin
    // one wait clock leaves no cycle to present the byte address before sampling
    if (FLASH_WAIT < 2 || FLASH_WAIT > 255) begin
      $error("FLASH_WAIT out of range");
    end
  end

  typedef enum {
    ST_IDLE,
    ST_DECODE,
    ST_FL_WDATA,
    ST_FL_WAIT,
    ST_XFER,
    ST_DRAIN,
    ST_TURN,
    ST_BUSY
  } state_t;

  typedef enum {
    SP_CFG,
    SP_CSR,
    SP_FLASH
  } space_t;

  // ----------------------------------------
  // command classes
  // ----------------------------------------
  function automatic logic is_mem_rd(input logic [3:0] c);
    return c == pci_target_pkg::CMD_MEM_RD || c == pci_target_pkg::CMD_MEM_RDM ||
           c == pci_target_pkg::CMD_MEM_RDL;
  endfunction

  function automatic logic is_mem_wr(input logic [3:0] c);
    return c == pci_target_pkg::CMD_MEM_WR || c == pci_target_pkg::CMD_MEM_WRI;
  endfunction

  function automatic logic base_hit(input logic [31:0] a, input logic [31:0] b,
                                    input int span);
    logic [31:0] m;
    m = 32'hffff_ffff << span;
    return (a & m) == (b & m);
  endfunction

  state_t      state_reg;
  space_t      space_reg;
  logic        write_reg;
  logic        frame_q;
  logic [31:0] addr_reg;
  logic        csr_ok_reg;
  logic        fl_start_reg;
  logic [3:0]  fl_be_reg;
  logic [31:0] fl_wdata_reg;
  logic        fl_done;
  logic [31:0] fl_rd_word;

  logic [3:0]  cmd;
  logic        addr_phase;
  logic        cfg_hit;
  logic        csr_mem_hit;
  logic        csr_io_hit;
  logic        fl_hit;
  logic        any_hit;
  logic        cmd_wr;

  // ----------------------------------------
  // address phase decode
  // ----------------------------------------
  assign cmd        = ~pci_i.cbe_n;
  assign addr_phase = !pci_i.frame_n && frame_q;
  assign cfg_hit    = pci_i.idsel && pci_i.ad[1:0] == pci_target_pkg::CFG_TYPE0_CODE &&
                      (cmd == pci_target_pkg::CMD_CFG_RD ||
                       cmd == pci_target_pkg::CMD_CFG_WR);
  assign csr_mem_hit = bars.mem_space_en && (is_mem_rd(cmd) || is_mem_wr(cmd)) &&
                       base_hit(pci_i.ad, bars.csr_mem_base,
                                pci_target_pkg::CSR_MEM_SPAN_BITS);
  assign csr_io_hit  = bars.io_space_en &&
                       (cmd == pci_target_pkg::CMD_IO_RD || cmd == pci_target_pkg::CMD_IO_WR) &&
                       base_hit(pci_i.ad, bars.csr_io_base,
                                pci_target_pkg::CSR_IO_SPAN_BITS);
  assign fl_hit      = bars.mem_space_en && (is_mem_rd(cmd) || is_mem_wr(cmd)) &&
                       (base_hit(pci_i.ad, bars.flash_base,
                                 pci_target_pkg::FLASH_SPAN_BITS) ||
                        (bars.rom_en && base_hit(pci_i.ad, bars.rom_base,
                                                 pci_target_pkg::FLASH_SPAN_BITS)));
  assign any_hit     = cfg_hit || csr_mem_hit || csr_io_hit || fl_hit;
  assign cmd_wr      = is_mem_wr(cmd) || cmd == pci_target_pkg::CMD_IO_WR ||
                       cmd == pci_target_pkg::CMD_CFG_WR;

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_q <= 1'b1;
    end else begin
      frame_q <= pci_i.frame_n;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      devsel_timing <= 2'h0;
    end else begin
      devsel_timing <= pci_target_pkg::DEVSEL_TIMING_MED;
    end
  end

  // ----------------------------------------
  // transaction sequencing
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      space_reg  <= SP_CFG;
      write_reg  <= 1'b0;
      addr_reg   <= 32'h0;
      csr_ok_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (addr_phase && any_hit) begin
            state_reg  <= ST_DECODE;
            write_reg  <= cmd_wr;
            addr_reg   <= pci_i.ad;
            space_reg  <= cfg_hit ? SP_CFG : (fl_hit ? SP_FLASH : SP_CSR);
            csr_ok_reg <= csr_io_hit ||
                          pci_i.ad[pci_target_pkg::CSR_MEM_SPAN_BITS-1:
                                   pci_target_pkg::CSR_IO_SPAN_BITS] == 7'h0;
          end else if (addr_phase) begin
            state_reg <= ST_BUSY;
          end
        end
        ST_DECODE: begin
          if (space_reg != SP_FLASH) begin
            state_reg <= ST_XFER;
          end else if (write_reg) begin
            state_reg <= ST_FL_WDATA;
          end else begin
            state_reg <= ST_FL_WAIT;
          end
        end
        ST_FL_WDATA: begin
          if (!pci_i.irdy_n) begin
            state_reg <= ST_FL_WAIT;
          end
        end
        ST_FL_WAIT: begin
          if (fl_done) begin
            state_reg <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (!pci_i.irdy_n) begin
            state_reg <= pci_i.frame_n ? ST_TURN : ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (pci_i.frame_n) begin
            state_reg <= ST_TURN;
          end
        end
        ST_TURN: begin
          state_reg <= ST_IDLE;
        end
        ST_BUSY: begin
          if (pci_i.frame_n && pci_i.irdy_n) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // target control and data pins
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pci_o <= pci_target_pkg::PCI_OUT_IDLE;
    end else begin
      case (state_reg)
        ST_DECODE: begin
          // devsel one clock after the decode edge gives medium timing
          pci_o.devsel_n <= 1'b0;
          pci_o.ctl_oe   <= 1'b1;
          pci_o.ad_oe    <= !write_reg;
          if (space_reg != SP_FLASH) begin
            pci_o.trdy_n <= 1'b0;
            pci_o.stop_n <= 1'b0;
            if (space_reg == SP_CFG) begin
              pci_o.ad <= cfg_rdata;
            end else begin
              pci_o.ad <= csr_ok_reg ? csr_rdata : 32'h0;
            end
          end
        end
        ST_FL_WDATA: begin
          // keep the claim while the initiator readies its write data
          pci_o.devsel_n <= 1'b0;
        end
        ST_FL_WAIT: begin
          if (fl_done) begin
            pci_o.trdy_n <= 1'b0;
            pci_o.stop_n <= 1'b0;
            pci_o.ad     <= fl_rd_word;
          end
        end
        ST_XFER: begin
          if (!pci_i.irdy_n) begin
            // only one data phase ever completes; stop stays until frame ends
            pci_o.trdy_n <= 1'b1;
            pci_o.ad_oe  <= 1'b0;
            if (pci_i.frame_n) begin
              pci_o.stop_n   <= 1'b1;
              pci_o.devsel_n <= 1'b1;
            end
          end
        end
        ST_DRAIN: begin
          if (pci_i.frame_n) begin
            pci_o.stop_n   <= 1'b1;
            pci_o.devsel_n <= 1'b1;
          end
        end
        ST_TURN: begin
          // lines were driven high for one clock before release
          pci_o.ctl_oe <= 1'b0;
        end
        default: begin
          pci_o <= pci_target_pkg::PCI_OUT_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // configuration and control/status access strobes
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_req <= pci_target_pkg::ACC_REQ_IDLE;
      csr_req <= pci_target_pkg::ACC_REQ_IDLE;
    end else begin
      cfg_req.rd <= 1'b0;
      cfg_req.wr <= 1'b0;
      csr_req.rd <= 1'b0;
      csr_req.wr <= 1'b0;
      if (state_reg == ST_IDLE && addr_phase && !cmd_wr) begin
        // read strobe at address phase so data is ready for zero-wait trdy
        if (cfg_hit) begin
          cfg_req.rd  <= 1'b1;
          cfg_req.idx <= pci_i.ad[7:2];
        end else if (csr_io_hit || csr_mem_hit) begin
          csr_req.rd  <= 1'b1;
          csr_req.idx <= {3'h0, pci_i.ad[4:2]};
        end
      end
      if (state_reg == ST_XFER && !pci_i.irdy_n && write_reg) begin
        if (space_reg == SP_CFG) begin
          cfg_req.wr    <= 1'b1;
          cfg_req.idx   <= addr_reg[7:2];
          cfg_req.be    <= ~pci_i.cbe_n;
          cfg_req.wdata <= pci_i.ad;
        end else if (space_reg == SP_CSR && csr_ok_reg) begin
          csr_req.wr    <= 1'b1;
          csr_req.idx   <= {3'h0, addr_reg[4:2]};
          csr_req.be    <= ~pci_i.cbe_n;
          csr_req.wdata <= pci_i.ad;
        end
      end
    end
  end

  // ----------------------------------------
  // flash launch
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      fl_start_reg <= 1'b0;
      fl_be_reg    <= 4'h0;
      fl_wdata_reg <= 32'h0;
    end else begin
      fl_start_reg <= 1'b0;
      if (state_reg == ST_DECODE && space_reg == SP_FLASH && !write_reg) begin
        fl_start_reg <= 1'b1;
        fl_be_reg    <= ~pci_i.cbe_n;
      end else if (state_reg == ST_FL_WDATA && !pci_i.irdy_n) begin
        fl_start_reg <= 1'b1;
        fl_be_reg    <= ~pci_i.cbe_n;
        fl_wdata_reg <= pci_i.ad;
      end
    end
  end

  flash_byte_engine #(
    .WAIT_CYCLES (FLASH_WAIT)
  ) u_flash (
    .clk      (clk),
    .rst      (rst),
    .start    (fl_start_reg),
    .write    (write_reg),
    .addr     (addr_reg[19:0]),
    .be       (fl_be_reg),
    .wdata    (fl_wdata_reg),
    .done     (fl_done),
    .rdata    (fl_rd_word),
    .fl_pins  (fl_pins),
    .fl_rdata (fl_rdata)
  );

endmodule

// >>> bench/pci_target_checker_assertions.sv
`timescale 1ns/100ps
module pci_target_checker #(
  parameter int FLASH_WAIT = 4
) (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire pci_target_pkg::pci_in_t  pci_i,
  input wire pci_target_pkg::pci_out_t pci_o,
  input wire pci_target_pkg::bar_cfg_t bars,
  input wire logic [1:0]               devsel_timing
);
  // ----
  // decode
  // ----
  logic is_cfg;
  logic io_hit;
  logic fl_hit;
  // command codes arrive inverted on the active-low command lines
  assign is_cfg = pci_i.cbe_n[3:1] == 3'h2;
  assign io_hit = pci_i.cbe_n[3:1] == 3'h6 && bars.io_space_en
                  && pci_i.ad[31:5] == bars.csr_io_base[31:5];
  assign fl_hit = pci_i.cbe_n inside {4'h9, 4'h8, 4'h3, 4'h1, 4'h0} && bars.mem_space_en
                  && pci_i.ad[31:20] == bars.flash_base[31:20];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // properties
  // ----
  a_cfg_claim: assert property ($fell(pci_i.frame_n) && is_cfg && pci_i.idsel
    && pci_i.ad[1:0] == 2'h0 |-> ##2 !pci_o.trdy_n && !pci_o.stop_n)
    else $error("config access not completed");
  a_idsel_low_ignored: assert property ($fell(pci_i.frame_n) && is_cfg && !pci_i.idsel
    |-> ##1 pci_o.devsel_n [*4])
    else $error("config access claimed without select");
  a_csr_zero_wait: assert property ($fell(pci_i.frame_n) && io_hit
    |-> ##2 !pci_o.trdy_n && !pci_o.devsel_n)
    else $error("csr access not zero wait");
  a_flash_slow: assert property ($fell(pci_i.frame_n) && fl_hit
    |=> pci_o.trdy_n [*4])
    else $error("flash ready too early");
  a_devsel_medium: assert property ($fell(pci_i.frame_n) |=> pci_o.devsel_n)
    else $error("select asserted with fast timing");
  a_trdy_holds: assert property (!pci_o.trdy_n && pci_i.irdy_n |=> !pci_o.trdy_n)
    else $error("ready dropped before initiator ready");
  a_one_phase: assert property (!pci_o.trdy_n && !pci_i.irdy_n |=> pci_o.trdy_n)
    else $error("second data phase allowed");
  a_stop_with_trdy: assert property (!pci_o.trdy_n |-> !pci_o.stop_n && !pci_o.devsel_n)
    else $error("ready without disconnect");
  a_timing_code: assert property (!$past(rst) |-> devsel_timing == 2'h1)
    else $error("timing code wrong");
  a_ctl_driven: assert property (!pci_o.devsel_n |-> pci_o.ctl_oe)
    else $error("select low while control lines released");
endmodule
bind pci_target_cfg_csr_flash pci_target_checker #(.FLASH_WAIT(FLASH_WAIT)) chk (
  .clk, .rst, .pci_i, .pci_o, .bars, .devsel_timing);

// >>> bench/pci_host_model.sv
`timescale 1ns/100ps
module pci_host_model (
  input wire logic                     clk,
  input wire pci_target_pkg::pci_out_t pci_o,
  output pci_target_pkg::pci_in_t      pci_i
);
  initial pci_i = '{frame_n: 1'b1, irdy_n: 1'b1, idsel: 1'b0, cbe_n: 4'hf, ad: 32'h0};
  // ----
  // one transaction, a single data phase only
  // ----
  task automatic xfer(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be,
                      input logic [31:0] wd, input logic sel, input int hold,
                      output logic [31:0] rd, output int lat, output logic stp);
    lat = -1;
    rd = 32'h0;
    stp = 1'b1;
    @(posedge clk);
    // command lines are active low like the byte enables
    #1 pci_i = '{frame_n: 1'b0, irdy_n: 1'b1, idsel: sel, cbe_n: ~cmd, ad: a};
    for (int i = 1; i < 400; i++) begin
      @(posedge clk);
      #1 pci_i.idsel = 1'b0;
      pci_i.cbe_n = ~be;
      pci_i.irdy_n = i <= hold;
      pci_i.frame_n = i > hold;
      // released lines toggle so a stale value never passes
      pci_i.ad = (!pci_i.irdy_n && cmd[0]) ? wd : ~pci_i.ad;
      if (!pci_i.irdy_n && !pci_o.trdy_n) begin
        rd = pci_o.ad;
        stp = pci_o.stop_n;
        lat = i;
        @(posedge clk);
        #1;
        break;
      end
      if (i >= 6 && pci_o.devsel_n) break;
    end
    pci_i = '{frame_n: 1'b1, irdy_n: 1'b1, idsel: 1'b0, cbe_n: 4'hf, ad: ~pci_i.ad};
    repeat (3) @(posedge clk);
  endtask
endmodule

// >>> bench/pci_target_cfg_csr_flash_bench.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module pci_target_cfg_csr_flash_bench;
  localparam int W = 2;
  logic                        clk;
  logic                        rst;
  pci_target_pkg::pci_in_t     pci_i;
  pci_target_pkg::pci_out_t    pci_o;
  pci_target_pkg::bar_cfg_t    bars;
  pci_target_pkg::acc_req_t    cfg_req;
  pci_target_pkg::acc_req_t    csr_req;
  pci_target_pkg::acc_req_t    last_wr;
  pci_target_pkg::flash_pins_t fl_pins;
  logic [31:0]                 cfg_rdata;
  logic [31:0]                 csr_rdata;
  logic [7:0]                  fl_rdata;
  logic [1:0]                  devsel_timing;
  logic [19:0]                 fl_wa;
  logic [7:0]                  fl_wd;
  logic [31:0]                 seed = 32'h000185fa;
  logic [31:0]                 rd;
  logic [31:0]                 a;
  logic [31:0]                 wd;
  logic [3:0]                  be;
  logic                        stp;
  int                          lat;
  int                          h;
  int                          ln;
  int                          err_total;
  int                          compares;
  logic [3:0]                  bes [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h6};

  pci_target_cfg_csr_flash #(.FLASH_WAIT(W)) dut (.clk, .rst, .pci_i, .pci_o, .bars,
    .cfg_req, .cfg_rdata, .csr_req, .csr_rdata, .fl_pins, .fl_rdata, .devsel_timing);
  pci_host_model host (.clk, .pci_o, .pci_i);

  // ----
  // far-side responders
  // ----
  assign cfg_rdata = {16'hc0f0, 10'h0, cfg_req.idx};
  assign csr_rdata = {16'h5e00, 10'h0, csr_req.idx};
  assign fl_rdata = fl_pins.addr[7:0] ^ 8'h5a;
  always @(posedge clk) begin
    if (csr_req.wr) last_wr <= csr_req;
    if (cfg_req.wr) last_wr <= cfg_req;
    if (fl_pins.wr_en) {fl_wa, fl_wd} <= {fl_pins.addr, fl_pins.wdata};
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----
  // expectations
  // ----
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int csr_lat(int hold);
    return (hold + 1 > 2) ? hold + 1 : 2;
  endfunction
  // only the two lowest enabled lanes come back, the rest read as zero
  function automatic logic [31:0] fl_exp(logic [31:0] ad, logic [3:0] en);
    logic [31:0] d;
    int n;
    d = 32'h0;
    n = 0;
    for (int l = 0; l < 4; l++) begin
      if (en[l] && n < 2) begin
        d[l*8 +: 8] = {ad[7:2], 2'(l)} ^ 8'h5a;
        n++;
      end
    end
    return d;
  endfunction
  task automatic run(logic [3:0] cmd, logic [31:0] ad, logic [3:0] en, logic sel, int hold);
    host.xfer(cmd, ad, en, wd, sel, hold, rd, lat, stp);
  endtask
  task final_report;
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    final_report;
  end
  initial begin
    err_total = 0;
    compares = 0;
    rst = 1'b1;
    wd = 32'h0;
    bars = '{csr_mem_base: 32'h80000000, csr_io_base: 32'h00001000, flash_base: 32'h90000000,
             rom_base: 32'ha0000000, mem_space_en: 1'b1, io_space_en: 1'b1, rom_en: 1'b1};
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (2) @(posedge clk);
    `CHK("timing code", 2'h1, devsel_timing)
    $display("test reset done");
    for (int k = 0; k < 8; k++) begin
      a = rnd() & 32'hfffffffc;
      be = 4'(rnd()) | 4'h1;
      h = rnd() % 3;
      wd = rnd();
      run(pci_target_pkg::CMD_CFG_RD, a, be, 1'b1, h);
      `CHK("cfg rdata", {16'hc0f0, 10'h0, a[7:2]}, rd)
      `CHK("cfg wait", csr_lat(h), lat)
      run(pci_target_pkg::CMD_CFG_WR, a, be, 1'b1, h);
      `CHK("cfg write", {a[7:2], be, wd}, {last_wr.idx, last_wr.be, last_wr.wdata})
      run(pci_target_pkg::CMD_CFG_RD, a, be, 1'b0, 0);
      `CHK("no select", -1, lat)
      run(pci_target_pkg::CMD_CFG_RD, a | 32'h1, be, 1'b1, 0);
      `CHK("bad type", -1, lat)
    end
    $display("test config done");
    for (int k = 0; k < 8; k++) begin
      a = ((k % 2) ? bars.csr_io_base : bars.csr_mem_base) | (rnd() & 32'h1c);
      be = 4'(rnd()) | 4'h2;
      h = rnd() % 3;
      wd = rnd();
      run((k % 2) ? 4'h2 : 4'h6, a, be, 1'b0, h);
      `CHK("csr rdata", {16'h5e00, 13'h0, a[4:2]}, rd)
      `CHK("csr wait", csr_lat(h), lat)
      run((k % 2) ? 4'h3 : 4'h7, a, be, 1'b0, h);
      `CHK("csr write", {3'h0, a[4:2], be, wd}, {last_wr.idx, last_wr.be, last_wr.wdata})
      `CHK("csr stop", 1'b0, stp)
    end
    run(pci_target_pkg::CMD_IO_RD, bars.csr_io_base + 32'h20, 4'hf, 1'b0, 0);
    `CHK("io window", -1, lat)
    run(pci_target_pkg::CMD_MEM_RD, bars.csr_mem_base + 32'h7fc, 4'hf, 1'b0, 0);
    `CHK("mem window", {32'h0, 32'h2}, {rd, lat})
    $display("test csr done");
    foreach (bes[j]) begin
      a = bars.flash_base | (rnd() & 32'hffffc);
      run(pci_target_pkg::CMD_MEM_RD, a, bes[j], 1'b0, 0);
      `CHK("flash rdata", fl_exp(a, bes[j]), rd)
      `CHK("flash wait", 5 + (($countones(bes[j]) > 1) ? 2 : 1) * W, lat)
      `CHK("flash stop", 1'b0, stp)
    end
    a = bars.rom_base | (rnd() & 32'hffffc);
    run(pci_target_pkg::CMD_MEM_RD, a, 4'h1, 1'b0, 0);
    `CHK("rom rdata", fl_exp(a, 4'h1), rd)
    #1 bars.rom_en = 1'b0;
    run(pci_target_pkg::CMD_MEM_RD, a, 4'h1, 1'b0, 0);
    `CHK("rom off", -1, lat)
    for (int j = 0; j < 3; j++) begin
      a = bars.flash_base | (rnd() & 32'hffffc);
      wd = rnd();
      be = bes[j + 4];
      ln = 0;
      for (int l = 3; l >= 0; l--) if (be[l]) ln = l;
      run(pci_target_pkg::CMD_MEM_WR, a, be, 1'b0, rnd() % 3);
      `CHK("flash write", {a[19:2], 2'(ln), wd[ln*8 +: 8]}, {fl_wa, fl_wd})
      `CHK("flash wr stop", 1'b0, stp)
    end
    $display("test flash done");
    final_report;
  end
endmodule
